// [tpv_cfg.svh]
/*
  register addresses, field positions, reset values and timing counts of the
  tuner test/synthesizer/oscillator control bank.
  assumes a 50 MHz system clock.
*/
`ifndef TPV_CFG_SVH
`define TPV_CFG_SVH

// ==========================================================================
// register addresses
`define TPV_ADDR_TEST 8'h00
`define TPV_ADDR_PLL 8'h01
`define TPV_ADDR_VCO 8'h02

// ==========================================================================
// reset values (recommended defaults)
`define TPV_RST_TEST 8'h10
`define TPV_RST_PLL 8'hf1
`define TPV_RST_VCO 8'hd8
// search pair and automatic pump code agree with the programmed defaults, so
// nothing moves on the first edge after reset
`define TPV_RST_BAND 5'h1b
`define TPV_RST_AUTO_PUMP 2'h3
`define TPV_RST_STATUS1 8'h1d

// ==========================================================================
// filter_trim_and_diagnostics fields
`define TPV_CENTER_HI 7
`define TPV_CENTER_LO 5
`define TPV_TRIM_SRC 4
`define TPV_MIX_DIS 3
`define TPV_DIAG_HI 2
`define TPV_DIAG_LO 0
`define TPV_CENTER_NOMINAL 3'h4
`define TPV_CENTER_RESERVED 3'h2

// ==========================================================================
// synth_charge_pump_control fields
`define TPV_PUMP_HI 7
`define TPV_PUMP_LO 6
`define TPV_PUMP_AUTO 5
`define TPV_PREBIAS_EN 4
`define TPV_REF_PB_TIME 3
`define TPV_LO_PB_TIME 2
`define TPV_PUMP_ON_TIME 1
`define TPV_AUTOSEL_EN 0

// ==========================================================================
// oscillator_selection fields
`define TPV_CORE_HI 7
`define TPV_CORE_LO 6
`define TPV_SUB_HI 5
`define TPV_SUB_LO 3
`define TPV_ADC_LATCH 2
`define TPV_ADC_READ 1
`define TPV_TIMING_CUR 0

// ==========================================================================
// timing
`define TPV_CLK_MHZ 50
`define TPV_REF_PB_SHORT_NS 280
`define TPV_REF_PB_LONG_NS 650
`define TPV_LO_PB_SHORT_NS 500
`define TPV_LO_PB_LONG_NS 1000
`define TPV_NS_TO_CYC(ns) (((ns) * `TPV_CLK_MHZ + 999) / 1000)
`define TPV_REF_PB_SHORT_CYC `TPV_NS_TO_CYC(`TPV_REF_PB_SHORT_NS)
`define TPV_REF_PB_LONG_CYC `TPV_NS_TO_CYC(`TPV_REF_PB_LONG_NS)
`define TPV_LO_PB_SHORT_CYC `TPV_NS_TO_CYC(`TPV_LO_PB_SHORT_NS)
`define TPV_LO_PB_LONG_CYC `TPV_NS_TO_CYC(`TPV_LO_PB_LONG_NS)
// settling wait per autoselect step, slower with the smaller timing current
`define TPV_SETTLE_1UA_CYC 7'h40
`define TPV_SETTLE_2UA_CYC 7'h20
// tuning-voltage adc codes that mean rail-low and rail-high
`define TPV_ADC_LOW 3'h0
`define TPV_ADC_HIGH 3'h7

`endif

// [tpv_pkg.sv]
/*
  types of the tuner control bank.
  assumes tpv_cfg.svh for numeric constants.
*/
package tpv_pkg;

  typedef enum logic [2:0] {
    DIAG_NORMAL,
    DIAG_PUMP_SOURCE,
    DIAG_PUMP_SINK,
    DIAG_PUMP_HIZ,
    DIAG_POWER_DETECT,
    DIAG_N_DIV,
    DIAG_R_DIV,
    DIAG_LO
  } tpv_diag_t;

  typedef enum logic [1:0] {
    TEST_PIN_OFF,
    TEST_PIN_N_DIV,
    TEST_PIN_R_DIV,
    TEST_PIN_LO
  } tpv_test_pin_t;

  typedef enum {
    AS_IDLE,
    AS_SETTLE,
    AS_CHECK
  } tpv_as_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } tpv_write_t;

  typedef struct packed {
    logic useFactoryTrim;
    logic [2:0] filterCenterCode;
    logic centerReserved;
    logic mixerDisable;
    logic forceSource;
    logic forceSink;
    logic forceHiZ;
    logic powerDetectPin;
    tpv_test_pin_t testPin;
    logic [1:0] pumpCurrent;
    logic pumpOnLong;
    logic pumpOn;
    logic prebiasActive;
    logic [1:0] oscCore;
    logic [2:0] oscSubband;
    logic timingCurrent2uA;
  } tpv_ctrl_t;

  typedef struct packed {
    logic [7:0] byte1;
    logic [7:0] byte2;
  } tpv_status_t;

endpackage : tpv_pkg

// [tpv_pulse_timer.sv]
/*
  one-shot timer: a start pulse holds active high for a loaded cycle count.
  assumes start and length are synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none

module tpv_pulse_timer
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [5:0] length,
  output logic active
);

  typedef struct packed {
    logic [5:0] count;
  } tpv_timer_state_t;

  tpv_timer_state_t state;
  tpv_timer_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (start)
    begin
      next_state.count = length;
    end
    else if (state.count != 6'h00)
    begin
      next_state.count = state.count - 6'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign active = (state.count != 6'h00);

endmodule : tpv_pulse_timer

`default_nettype wire

// [tpv_regs.sv]
/*
  test, synthesizer and oscillator control registers of the tuner, with the
  oscillator autoselect search, tuning adc capture and prebias timing.
  assumes the two-wire slave delivers each decoded register write as one
  strobe with address and data, and a pulse when a status read ends.
*/
// Contract
// - three-bit centre code scales filter centre; 100 nominal; used only without trim
// - trim source one uses factory trim, zero uses manual centre code
// - mixer disable one turns quadrature mixers off, zero runs them
// - diagnostic codes 000-011: normal, force source, force sink, pump high-z
// - diagnostic 100 power detector pin; 101-111 N, R, LO on test pin
// - two-bit pump current code: 1.5 mA plus 0.5 mA per step
// - pump current auto picks current from adc reads, else manual code
// - prebias enable bit turns charge-pump prebias on or off
// - reference divider prebias time: 280 ns or 650 ns
// - lo divider prebias time: 500 ns or 1000 ns
// - pump on-time bit: 2.5 ns or 5 ns
// - autoselect enable runs search; zero uses manual core and sub-band
// - core select picks one of four oscillators; autoselect start point
// - sub-band select picks sub-band 0-7; autoselect start point
// - with autoselect off, adc latch bit freezes tuning adc value
// - timing current bit: 1 uA or 2 uA for autoselect time constant
// - status returns the pump current in effect, same encoding
// - status bit is one only when autoselect succeeded
`timescale 1ns/100ps
`default_nettype none
`include "tpv_cfg.svh"

module tpv_regs
(
  input wire logic clk,
  input wire logic reset_n,
  input wire tpv_pkg::tpv_write_t wr,
  input wire logic statusReadDone,
  input wire logic [2:0] tuneAdc,
  input wire logic refDivEvent,
  input wire logic loDivEvent,
  input wire logic phaseEvent,
  output var tpv_pkg::tpv_ctrl_t ctrl,
  output var tpv_pkg::tpv_status_t status
);
  import tpv_pkg::*;

  // ========================================================================
  // state
  typedef struct packed {
    logic [7:0] test;
    logic [7:0] pll;
    logic [7:0] oscillator_selection;
    tpv_as_state_t asState;
    logic [4:0] band;
    logic [6:0] settleCnt;
    logic [2:0] adcValue;
    logic [1:0] autoPump;
    logic success;
    logic powerCycled;
    logic pumpOn;
    tpv_ctrl_t ctrl;
    tpv_status_t status;
  } tpv_state_t;

  tpv_state_t state;
  tpv_state_t next_state;

  logic refPrebias;
  logic loPrebias;
  logic [5:0] refLength;
  logic [5:0] loLength;

  // ========================================================================
  // helpers

  // lower adc readings mean a low tuning voltage and a weaker loop, so
  // the pump is pushed harder there
  function automatic logic [1:0] pumpFromAdc(input logic [2:0] adc);
    logic [1:0] code;
    code = 2'h3 - adc[2:1];
    return code;
  endfunction : pumpFromAdc

  function automatic logic [6:0] settleTime(input logic current2uA);
    logic [6:0] cycles;
    cycles = current2uA ? `TPV_SETTLE_2UA_CYC : `TPV_SETTLE_1UA_CYC;
    return cycles;
  endfunction : settleTime

  // ========================================================================
  // prebias timers
  always_comb
  begin
    refLength = state.pll[`TPV_REF_PB_TIME] ? 6'(`TPV_REF_PB_LONG_CYC)
                                             : 6'(`TPV_REF_PB_SHORT_CYC);
    loLength = state.pll[`TPV_LO_PB_TIME] ? 6'(`TPV_LO_PB_LONG_CYC)
                                           : 6'(`TPV_LO_PB_SHORT_CYC);
  end

  tpv_pulse_timer refTimer
  (
    .clk(clk),
    .reset_n(reset_n),
    .start(refDivEvent && state.pll[`TPV_PREBIAS_EN]),
    .length(refLength),
    .active(refPrebias)
  );

  tpv_pulse_timer loTimer
  (
    .clk(clk),
    .reset_n(reset_n),
    .start(loDivEvent && state.pll[`TPV_PREBIAS_EN]),
    .length(loLength),
    .active(loPrebias)
  );

  // ========================================================================
  // next state
  always_comb
  begin
    logic autoEn;
    logic startSearch;
    logic adcSample;
    logic [2:0] code;
    logic [2:0] diag;
    next_state = state;
    autoEn = 1'b0;
    startSearch = 1'b0;
    adcSample = 1'b0;
    code = 3'h0;
    diag = 3'h0;

    // register writes; the host is expected to program every register
    // after power-up, the reset values only stand in until then
    if (wr.valid)
    begin
      if (wr.addr == `TPV_ADDR_TEST)
      begin
        next_state.test = wr.data;
      end
      else if (wr.addr == `TPV_ADDR_PLL)
      begin
        next_state.pll = wr.data;
        startSearch = 1'b1;
      end
      else if (wr.addr == `TPV_ADDR_VCO)
      begin
        next_state.oscillator_selection = wr.data;
        startSearch = 1'b1;
      end
    end
    autoEn = next_state.pll[`TPV_AUTOSEL_EN];

    // autoselect search over the 32 core/sub-band pairs
    case (state.asState)
      AS_IDLE:
      begin
      end
      AS_SETTLE:
      begin
        if (state.settleCnt != 7'h00)
        begin
          next_state.settleCnt = state.settleCnt - 7'h01;
        end
        else
        begin
          next_state.asState = AS_CHECK;
        end
      end
      AS_CHECK:
      begin
        adcSample = 1'b1;
        next_state.asState = AS_SETTLE;
        next_state.settleCnt = settleTime(state.oscillator_selection[`TPV_TIMING_CUR]);
        if (tuneAdc == `TPV_ADC_LOW)
        begin
          if (state.band == 5'h00)
          begin
            next_state.asState = AS_IDLE;
          end
          else
          begin
            next_state.band = state.band - 5'h01;
          end
        end
        else if (tuneAdc == `TPV_ADC_HIGH)
        begin
          if (state.band == 5'h1f)
          begin
            next_state.asState = AS_IDLE;
          end
          else
          begin
            next_state.band = state.band + 5'h01;
          end
        end
        else
        begin
          next_state.asState = AS_IDLE;
          next_state.success = 1'b1;
        end
      end
      default:
      begin
        next_state.asState = AS_IDLE;
      end
    endcase

    // a new synthesizer or oscillator write restarts the search from the programmed pair
    if (startSearch && autoEn)
    begin
      next_state.asState = AS_SETTLE;
      next_state.band = {next_state.oscillator_selection[`TPV_CORE_HI:`TPV_CORE_LO],
                         next_state.oscillator_selection[`TPV_SUB_HI:`TPV_SUB_LO]};
      next_state.settleCnt = settleTime(next_state.oscillator_selection[`TPV_TIMING_CUR]);
      next_state.success = 1'b0;
    end
    else if (!autoEn)
    begin
      next_state.asState = AS_IDLE;
      next_state.success = 1'b0;
    end

    // manual mode: reads allowed by read enable, frozen by the latch bit
    if (!autoEn && state.oscillator_selection[`TPV_ADC_READ] && !state.oscillator_selection[`TPV_ADC_LATCH])
    begin
      adcSample = 1'b1;
    end
    if (adcSample)
    begin
      next_state.adcValue = tuneAdc;
      next_state.autoPump = pumpFromAdc(tuneAdc);
    end

    // power-cycle flag falls when a status read ends
    if (statusReadDone)
    begin
      next_state.powerCycled = 1'b0;
    end

    // pump on-time shorter than a clock period: one cycle per phase event
    next_state.pumpOn = phaseEvent;

    // ----------------------------------------------------------------------
    // registered control outputs
    code = next_state.test[`TPV_CENTER_HI:`TPV_CENTER_LO];
    diag = next_state.test[`TPV_DIAG_HI:`TPV_DIAG_LO];
    next_state.ctrl.useFactoryTrim = next_state.test[`TPV_TRIM_SRC];
    next_state.ctrl.centerReserved = (code == `TPV_CENTER_RESERVED);
    // the reserved code has no defined scaling, so nominal is driven instead
    next_state.ctrl.filterCenterCode = (code == `TPV_CENTER_RESERVED)
                                       ? `TPV_CENTER_NOMINAL : code;
    next_state.ctrl.mixerDisable = next_state.test[`TPV_MIX_DIS];
    next_state.ctrl.forceSource = (diag == DIAG_PUMP_SOURCE);
    next_state.ctrl.forceSink = (diag == DIAG_PUMP_SINK);
    next_state.ctrl.forceHiZ = (diag == DIAG_PUMP_HIZ);
    next_state.ctrl.powerDetectPin = (diag == DIAG_POWER_DETECT);
    if (diag == DIAG_N_DIV)
    begin
      next_state.ctrl.testPin = TEST_PIN_N_DIV;
    end
    else if (diag == DIAG_R_DIV)
    begin
      next_state.ctrl.testPin = TEST_PIN_R_DIV;
    end
    else if (diag == DIAG_LO)
    begin
      next_state.ctrl.testPin = TEST_PIN_LO;
    end
    else
    begin
      next_state.ctrl.testPin = TEST_PIN_OFF;
    end
    next_state.ctrl.pumpCurrent = next_state.pll[`TPV_PUMP_AUTO]
                                  ? next_state.autoPump
                                  : next_state.pll[`TPV_PUMP_HI:`TPV_PUMP_LO];
    next_state.ctrl.pumpOnLong = next_state.pll[`TPV_PUMP_ON_TIME];
    next_state.ctrl.pumpOn = next_state.pumpOn;
    next_state.ctrl.prebiasActive = refPrebias || loPrebias;
    if (autoEn)
    begin
      next_state.ctrl.oscCore = next_state.band[4:3];
      next_state.ctrl.oscSubband = next_state.band[2:0];
    end
    else
    begin
      next_state.ctrl.oscCore = next_state.oscillator_selection[`TPV_CORE_HI:`TPV_CORE_LO];
      next_state.ctrl.oscSubband = next_state.oscillator_selection[`TPV_SUB_HI:`TPV_SUB_LO];
    end
    next_state.ctrl.timingCurrent2uA = next_state.oscillator_selection[`TPV_TIMING_CUR];

    // ----------------------------------------------------------------------
    // registered status bytes
    next_state.status.byte1 = {3'h0,
                               next_state.ctrl.pumpCurrent,
                               next_state.powerCycled,
                               next_state.success,
                               next_state.asState == AS_IDLE};
    next_state.status.byte2 = {next_state.ctrl.oscCore,
                               next_state.ctrl.oscSubband,
                               next_state.adcValue};
  end

  // ========================================================================
  // registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.test <= `TPV_RST_TEST;
      state.pll <= `TPV_RST_PLL;
      state.oscillator_selection <= `TPV_RST_VCO;
      state.asState <= AS_IDLE;
      state.band <= `TPV_RST_BAND;
      state.autoPump <= `TPV_RST_AUTO_PUMP;
      state.powerCycled <= 1'b1;
      state.ctrl.useFactoryTrim <= 1'b1;
      state.ctrl.filterCenterCode <= 3'h0;
      state.ctrl.pumpCurrent <= 2'h3;
      state.ctrl.oscCore <= 2'h3;
      state.ctrl.oscSubband <= 3'h3;
      state.status <= '{byte1: `TPV_RST_STATUS1, byte2: `TPV_RST_VCO};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign ctrl = state.ctrl;
  assign status = state.status;

endmodule : tpv_regs

`default_nettype wire

// [tpv_regs_checker.sv]
/*
  concurrent checks of the tuner control bank, bound to tpv_regs.
  assumes one clock domain and writes one strobe at a time.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tpv_cfg.svh"

module tpv_regs_checker
(
  input wire logic clk,
  input wire logic reset_n,
  input wire tpv_pkg::tpv_write_t wr,
  input wire logic statusReadDone,
  input wire logic [2:0] tuneAdc,
  input wire logic refDivEvent,
  input wire logic loDivEvent,
  input wire logic phaseEvent,
  input wire tpv_pkg::tpv_ctrl_t ctrl,
  input wire tpv_pkg::tpv_status_t status
);
  import tpv_pkg::*;
  // ========================================================================
  // shadow registers and counters
  logic [7:0] tst, pll, oscillator_selection;
  logic [5:0] runLen, expLen;
  logic [1:0] adcAge;
  logic [2:0] adcPrev;
  logic tstWr, pllWr, vcoWr, adcOpen;
  assign tstWr = wr.valid && wr.addr == `TPV_ADDR_TEST;
  assign pllWr = wr.valid && wr.addr == `TPV_ADDR_PLL;
  assign vcoWr = wr.valid && wr.addr == `TPV_ADDR_VCO;
  assign adcOpen = !pll[0] && oscillator_selection[1] && !oscillator_selection[2] && !wr.valid && tuneAdc == adcPrev;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tst <= `TPV_RST_TEST;
      pll <= `TPV_RST_PLL;
      oscillator_selection <= `TPV_RST_VCO;
      runLen <= 6'h00;
      expLen <= 6'h00;
      adcAge <= 2'h0;
      adcPrev <= 3'h0;
    end
    else
    begin
      if (tstWr) tst <= wr.data;
      if (pllWr) pll <= wr.data;
      if (vcoWr) oscillator_selection <= wr.data;
      runLen <= ctrl.prebiasActive ? runLen + 6'h01 : 6'h00;
      if (refDivEvent)
        expLen <= pll[3] ? 6'(`TPV_REF_PB_LONG_CYC) : 6'(`TPV_REF_PB_SHORT_CYC);
      else if (loDivEvent)
        expLen <= pll[2] ? 6'(`TPV_LO_PB_LONG_CYC) : 6'(`TPV_LO_PB_SHORT_CYC);
      adcAge <= !adcOpen ? 2'h0 : (adcAge == 2'h3 ? adcAge : adcAge + 2'h1);
      adcPrev <= tuneAdc;
    end
  end
  // ========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  test_fields_a: assert property ($past(tstWr) |->
    ctrl.useFactoryTrim == tst[4] && ctrl.mixerDisable == tst[3])
    else $error("trim source or mixer disable wrong");
  center_code_a: assert property ($past(tstWr) |->
    ctrl.centerReserved == (tst[7:5] == `TPV_CENTER_RESERVED) && ctrl.filterCenterCode ==
    (tst[7:5] == `TPV_CENTER_RESERVED ? `TPV_CENTER_NOMINAL : tst[7:5]))
    else $error("centre code wrong");
  diag_decode_a: assert property ($past(tstWr) |->
    ctrl.forceSource == (tst[2:0] == 3'h1) && ctrl.forceSink == (tst[2:0] == 3'h2) &&
    ctrl.forceHiZ == (tst[2:0] == 3'h3) && ctrl.powerDetectPin == (tst[2:0] == 3'h4) &&
    ctrl.testPin == (tst[2] ? tst[1:0] : 2'h0))
    else $error("diagnostic decode wrong");
  pump_manual_a: assert property ($past(pllWr) && !pll[5] |-> ctrl.pumpCurrent == pll[7:6])
    else $error("manual pump current wrong");
  pump_status_a: assert property (ctrl.pumpCurrent == $past(ctrl.pumpCurrent) |->
    status.byte1[4:3] == ctrl.pumpCurrent)
    else $error("status pump current wrong");
  pump_on_a: assert property (phaseEvent |=> ctrl.pumpOn && ctrl.pumpOnLong == pll[1])
    else $error("pump on pulse wrong");
  prebias_len_a: assert property ($fell(ctrl.prebiasActive) |-> runLen == expLen)
    else $error("prebias length wrong");
  prebias_off_a: assert property ((refDivEvent || loDivEvent) && !pll[4] &&
    !ctrl.prebiasActive |=> ##1 !ctrl.prebiasActive)
    else $error("prebias while disabled");
  manual_osc_a: assert property (!pll[0] && !$past(pll[0]) |->
    ctrl.oscCore == oscillator_selection[7:6] && ctrl.oscSubband == oscillator_selection[5:3])
    else $error("manual oscillator wrong");
  timing_cur_a: assert property (ctrl.timingCurrent2uA == oscillator_selection[0])
    else $error("timing current wrong");
  success_off_a: assert property (!pll[0] && !$past(pll[0]) |-> status.byte1[1:0] == 2'h1)
    else $error("success set while autoselect off");
  adc_track_a: assert property (adcAge == 2'h3 |-> status.byte2[2:0] == adcPrev)
    else $error("adc value not tracking");
  prebias_c: cover property ($fell(ctrl.prebiasActive));
  success_c: cover property (status.byte1[1]);
  adc_c: cover property (adcAge == 2'h3);
endmodule : tpv_regs_checker

bind tpv_regs tpv_regs_checker chk_u (.clk(clk), .reset_n(reset_n), .wr(wr),
  .statusReadDone(statusReadDone), .tuneAdc(tuneAdc), .refDivEvent(refDivEvent),
  .loDivEvent(loDivEvent), .phaseEvent(phaseEvent), .ctrl(ctrl), .status(status));
`default_nettype wire

// [tpv_host.sv]
/*
  host model: delivers register writes and status read ends.
  assumes its tasks are called from the testbench at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none

module tpv_host
(
  input wire logic clk,
  input wire logic reset_n,
  output var tpv_pkg::tpv_write_t wr,
  output var logic statusReadDone
);
  import tpv_pkg::*;
  initial
  begin
    wr = '{1'b0, 8'hff, 8'h00};
    statusReadDone = 1'b0;
  end
  // ========================================================================
  // bus tasks
  task automatic power_up_wait();
    repeat (5000) @(negedge clk);
  endtask : power_up_wait
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr <= '{1'b1, a, d};
    @(negedge clk);
    // released lines show the inverse so stale data is never mistaken
    wr <= '{1'b0, ~a, ~d};
  endtask : write_reg
  task automatic end_read();
    @(negedge clk);
    statusReadDone <= 1'b1;
    @(negedge clk);
    statusReadDone <= 1'b0;
  endtask : end_read
endmodule : tpv_host
`default_nettype wire

// [tpv_regs_tb.sv]
/*
  self-checking testbench of the tuner control bank.
  assumes tpv_host drives the write strobe; events are driven here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tpv_cfg.svh"

module tpv_regs_tb;
  import tpv_pkg::*;
  logic clk, reset_n, statusReadDone, refDivEvent, loDivEvent, phaseEvent;
  logic [2:0] tuneAdc;
  tpv_write_t wr;
  tpv_ctrl_t ctrl;
  tpv_status_t status;
  int num_errors, n_compared, i;
  tpv_host host_u (.clk(clk), .reset_n(reset_n), .wr(wr), .statusReadDone(statusReadDone));
  tpv_regs dut_u (.clk(clk), .reset_n(reset_n), .wr(wr), .statusReadDone(statusReadDone),
    .tuneAdc(tuneAdc), .refDivEvent(refDivEvent), .loDivEvent(loDivEvent),
    .phaseEvent(phaseEvent), .ctrl(ctrl), .status(status));
  always #10 clk = ~clk;
  // ========================================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : check
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic pb(input logic [7:0] pllv, input logic useRef, input int exp);
    int cnt;
    cnt = 0;
    host_u.write_reg(`TPV_ADDR_PLL, pllv);
    refDivEvent = useRef;
    loDivEvent = !useRef;
    tick(1);
    refDivEvent = 1'b0;
    loDivEvent = 1'b0;
    repeat (70)
    begin
      tick(1);
      if (ctrl.prebiasActive === 1'b1) cnt++;
    end
    check(16'(cnt), 16'(exp));
  endtask : pb
  task automatic wait_idle();
    int n;
    n = 0;
    tick(2);
    while (status.byte1[0] !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    if (n == 3000)
    begin
      num_errors++;
      give_verdict();
    end
  endtask : wait_idle
  // ========================================================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    tuneAdc = 3'h3;
    refDivEvent = 1'b0;
    loDivEvent = 1'b0;
    phaseEvent = 1'b0;
    num_errors = 0;
    n_compared = 0;
    tick(10);
    reset_n = 1'b1;
    tick(1);
    check(status.byte1, 8'h1d);
    check({ctrl.useFactoryTrim, ctrl.pumpCurrent, ctrl.oscCore, ctrl.oscSubband}, 8'hfb);
    host_u.end_read();
    tick(1);
    check(status.byte1[4:0], 5'h19);
    host_u.power_up_wait();
    host_u.write_reg(`TPV_ADDR_PLL, 8'hf0);
    host_u.write_reg(`TPV_ADDR_VCO, `TPV_RST_VCO);
    for (i = 0; i < 8; i++)
    begin
      host_u.write_reg(`TPV_ADDR_TEST, {i[2:0], 1'b0, i[0], i[2:0]});
      check({ctrl.useFactoryTrim, ctrl.mixerDisable, ctrl.filterCenterCode, ctrl.centerReserved},
        {1'b0, i[0], (i == 2) ? 3'h4 : i[2:0], i == 2});
      check({ctrl.forceSource, ctrl.forceSink, ctrl.forceHiZ, ctrl.powerDetectPin, ctrl.testPin},
        {i == 1, i == 2, i == 3, i == 4, (i >= 5) ? i[1:0] : 2'h0});
    end
    host_u.write_reg(`TPV_ADDR_TEST, `TPV_RST_TEST);
    check(ctrl.useFactoryTrim, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      host_u.write_reg(`TPV_ADDR_PLL, {i[1:0], 6'h00});
      tick(2);
      check({ctrl.pumpCurrent, status.byte1[4:3]}, {i[1:0], i[1:0]});
    end
    // automatic pump current follows the adc reading: 3 minus its top bits
    tuneAdc = 3'h2;
    host_u.write_reg(`TPV_ADDR_VCO, 8'h02);
    host_u.write_reg(`TPV_ADDR_PLL, 8'h20);
    tick(4);
    check(ctrl.pumpCurrent, 2'h2);
    tuneAdc = 3'h5;
    tick(4);
    check(status.byte2[2:0], 3'h5);
    host_u.write_reg(`TPV_ADDR_VCO, 8'h06);
    tick(3);
    tuneAdc = 3'h1;
    tick(4);
    check(status.byte2[2:0], 3'h5);
    for (i = 0; i < 2; i++)
    begin
      host_u.write_reg(`TPV_ADDR_VCO, i ? 8'hba : 8'h45);
      tick(2);
      check({ctrl.oscCore, ctrl.oscSubband, ctrl.timingCurrent2uA, status.byte2[7:3]},
        i ? 11'h5d7 : 11'h228);
    end
    host_u.write_reg(`TPV_ADDR_PLL, 8'h22);
    phaseEvent = 1'b1;
    tick(1);
    phaseEvent = 1'b0;
    check({ctrl.pumpOn, ctrl.pumpOnLong}, 2'h3);
    tick(1);
    check(ctrl.pumpOn, 1'b0);
    pb(8'h10, 1'b1, `TPV_REF_PB_SHORT_CYC);
    pb(8'h18, 1'b1, `TPV_REF_PB_LONG_CYC);
    pb(8'h10, 1'b0, `TPV_LO_PB_SHORT_CYC);
    pb(8'h14, 1'b0, `TPV_LO_PB_LONG_CYC);
    pb(8'h00, 1'b1, 0);
    tuneAdc = 3'h3;
    host_u.write_reg(`TPV_ADDR_VCO, 8'h51);
    host_u.write_reg(`TPV_ADDR_PLL, 8'h01);
    wait_idle();
    check({status.byte1[1:0], ctrl.oscCore, ctrl.oscSubband}, 7'h6a);
    // rail-high one band below the top: steps up once, then has nowhere to go
    tuneAdc = 3'h7;
    host_u.write_reg(`TPV_ADDR_VCO, 8'hf1);
    wait_idle();
    check({status.byte1[1:0], ctrl.oscCore, ctrl.oscSubband}, 7'h3f);
    host_u.write_reg(`TPV_ADDR_PLL, 8'h00);
    tick(2);
    check({status.byte1[1:0], ctrl.oscCore, ctrl.oscSubband}, 7'h3e);
    give_verdict();
  end
endmodule : tpv_regs_tb
`default_nettype wire
